// ==== jdtp_port.sv ====
// Purpose: test-access port, debug control and program-counter trace
// Assumes: test pins are oversampled by clk, so tck must stay well below clk / 4
// Notes:   one clock domain; pin edges are found after a two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
`include "jdtp_cfg.svh"

module jdtp_port #(
    parameter int PC_W = `JDTP_PC_W
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire jdtp_pkg::jdtp_pin_in_s  pin_in,
    output jdtp_pkg::jdtp_pin_out_s      pin_out,
    input  wire logic                    core_pc_valid,
    input  wire logic [PC_W-1:0]         core_pc,
    input  wire logic [2:0]              core_pcst,
    output logic                         core_pc_ready,
    output logic                         trace_active
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0]            sync1;
    logic [3:0]            sync2;
    logic                  tck_d;
    logic                  tck_s;
    logic                  tms_s;
    logic                  tdi_s;
    logic                  trst_s;
    logic                  tck_rise;
    logic                  tck_fall;

    // pins are asynchronous to clk, so tck is only ever sampled here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 4'h1;
            sync2 <= 4'h1;
            tck_d <= 1'b0;
        end else begin
            sync1 <= {pin_in.tck, pin_in.tms, pin_in.tdi, pin_in.trst_n};
            sync2 <= sync1;
            tck_d <= sync2[3];
        end
    end

    assign tck_s    = sync2[3];
    assign tms_s    = sync2[2];
    assign tdi_s    = sync2[1];
    assign trst_s   = sync2[0];
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // ----------------------------------------------------------------
    // tap controller
    // ----------------------------------------------------------------
    jdtp_pkg::jdtp_tap_e   tap;
    jdtp_pkg::jdtp_tap_e   next_tap;

    always_comb begin
        next_tap = tap;
        unique case (tap)
            jdtp_pkg::TAP_TLR:  next_tap = tms_s ? jdtp_pkg::TAP_TLR  : jdtp_pkg::TAP_RTI;
            jdtp_pkg::TAP_RTI:  next_tap = tms_s ? jdtp_pkg::TAP_SDRS : jdtp_pkg::TAP_RTI;
            jdtp_pkg::TAP_SDRS: next_tap = tms_s ? jdtp_pkg::TAP_SIRS : jdtp_pkg::TAP_CDR;
            jdtp_pkg::TAP_CDR:  next_tap = tms_s ? jdtp_pkg::TAP_E1DR : jdtp_pkg::TAP_SDR;
            jdtp_pkg::TAP_SDR:  next_tap = tms_s ? jdtp_pkg::TAP_E1DR : jdtp_pkg::TAP_SDR;
            jdtp_pkg::TAP_E1DR: next_tap = tms_s ? jdtp_pkg::TAP_UDR  : jdtp_pkg::TAP_PDR;
            jdtp_pkg::TAP_PDR:  next_tap = tms_s ? jdtp_pkg::TAP_E2DR : jdtp_pkg::TAP_PDR;
            jdtp_pkg::TAP_E2DR: next_tap = tms_s ? jdtp_pkg::TAP_UDR  : jdtp_pkg::TAP_SDR;
            jdtp_pkg::TAP_UDR:  next_tap = tms_s ? jdtp_pkg::TAP_SDRS : jdtp_pkg::TAP_RTI;
            jdtp_pkg::TAP_SIRS: next_tap = tms_s ? jdtp_pkg::TAP_TLR  : jdtp_pkg::TAP_CIR;
            jdtp_pkg::TAP_CIR:  next_tap = tms_s ? jdtp_pkg::TAP_E1IR : jdtp_pkg::TAP_SIR;
            jdtp_pkg::TAP_SIR:  next_tap = tms_s ? jdtp_pkg::TAP_E1IR : jdtp_pkg::TAP_SIR;
            jdtp_pkg::TAP_E1IR: next_tap = tms_s ? jdtp_pkg::TAP_UIR  : jdtp_pkg::TAP_PIR;
            jdtp_pkg::TAP_PIR:  next_tap = tms_s ? jdtp_pkg::TAP_E2IR : jdtp_pkg::TAP_PIR;
            jdtp_pkg::TAP_E2IR: next_tap = tms_s ? jdtp_pkg::TAP_UIR  : jdtp_pkg::TAP_SIR;
            jdtp_pkg::TAP_UIR:  next_tap = tms_s ? jdtp_pkg::TAP_SDRS : jdtp_pkg::TAP_RTI;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tap <= jdtp_pkg::TAP_TLR;
        end else if (!trst_s) begin
            tap <= jdtp_pkg::TAP_TLR;
        end else if (tck_rise) begin
            tap <= next_tap;
        end
    end

    // ----------------------------------------------------------------
    // instruction and data registers
    // ----------------------------------------------------------------
    logic [`JDTP_IR_W-1:0]  ir;
    logic [`JDTP_IR_W-1:0]  ir_sr;
    logic [31:0]            dr_sr;
    logic [`JDTP_CTL_W-1:0] ctl;
    logic                   trace_mode;
    logic [`JDTP_CTL_DIV_W-1:0] div;

    assign trace_mode = ctl[`JDTP_CTL_MODE_BIT];
    assign div        = ctl[`JDTP_CTL_DIV_LSB +: `JDTP_CTL_DIV_W];

    // shifts a bit in at the top of the selected register length
    function automatic logic [31:0] dr_shift(input logic [31:0] sr, input logic b,
                                             input logic [`JDTP_IR_W-1:0] op);
        logic [31:0] r;
        r = {b, sr[31:1]};
        if (op == `JDTP_IR_DBGCTL) begin
            r = {27'h0, b, sr[`JDTP_CTL_W-1:1]};
        end else if (op != `JDTP_IR_IDCODE) begin
            r = {31'h0, b};
        end
        return r;
    endfunction

    // in trace mode the data-in pin is the debug interrupt, so nothing shifts from it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir    <= `JDTP_IR_IDCODE;
            ir_sr <= '0;
            dr_sr <= '0;
        end else if (!trst_s) begin
            ir    <= `JDTP_IR_IDCODE;
        end else if (tck_rise) begin
            unique case (tap)
                jdtp_pkg::TAP_TLR: ir <= `JDTP_IR_IDCODE;
                jdtp_pkg::TAP_CIR: ir_sr <= `JDTP_IR_CAPTURE;
                jdtp_pkg::TAP_SIR: ir_sr <= {tdi_s & ~trace_mode, ir_sr[`JDTP_IR_W-1:1]};
                jdtp_pkg::TAP_UIR: ir <= ir_sr;
                jdtp_pkg::TAP_CDR: begin
                    if (ir == `JDTP_IR_IDCODE) begin
                        dr_sr <= `JDTP_IDCODE_VAL;
                    end else if (ir == `JDTP_IR_DBGCTL) begin
                        dr_sr <= {27'h0, ctl};
                    end else begin
                        dr_sr <= '0;
                    end
                end
                jdtp_pkg::TAP_SDR: dr_sr <= dr_shift(dr_sr, tdi_s & ~trace_mode, ir);
                default: ;
            endcase
        end
    end

    // debug control; a debug interrupt wins over a simultaneous update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= `JDTP_CTL_RESET;
        end else if (!trst_s) begin
            ctl <= `JDTP_CTL_RESET;
        end else if (trace_mode && !tdi_s) begin
            ctl[`JDTP_CTL_MODE_BIT] <= 1'b0;
        end else if (tck_rise && tap == jdtp_pkg::TAP_UDR && ir == `JDTP_IR_DBGCTL) begin
            ctl <= dr_sr[`JDTP_CTL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // serial scan output
    // ----------------------------------------------------------------
    logic                  scan_tdo;
    logic                  scan_oe;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scan_tdo <= 1'b0;
            scan_oe  <= 1'b0;
        end else if (tck_fall) begin
            scan_tdo <= (tap == jdtp_pkg::TAP_SIR) ? ir_sr[0] : dr_sr[0];
            scan_oe  <= (tap == jdtp_pkg::TAP_SIR) || (tap == jdtp_pkg::TAP_SDR);
        end
    end

    // ----------------------------------------------------------------
    // trace clock and program-counter stream
    // ----------------------------------------------------------------
    logic [`JDTP_CTL_DIV_W-1:0] div_cnt;
    logic                  dclk;
    logic                  dclk_fall;
    logic [PC_W-1:0]       tsr;
    logic [5:0]            tbits;
    logic                  tpc;

    // half period is div+1 clk cycles; div 0 gives clk / 2
    assign dclk_fall     = trace_mode && dclk && (div_cnt == div);
    assign core_pc_ready = trace_mode && (tbits == 6'h00);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            dclk    <= 1'b0;
        end else if (!trace_mode) begin
            div_cnt <= '0;
            dclk    <= 1'b0;
        end else if (div_cnt == div) begin
            div_cnt <= '0;
            dclk    <= ~dclk;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // the core offers only non-sequential pcs; one is held until fully sent
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tsr   <= '0;
            tbits <= '0;
            tpc   <= 1'b0;
        end else if (!trace_mode) begin
            tbits <= '0;
            tpc   <= 1'b0;
        end else if (core_pc_valid && core_pc_ready) begin
            tsr   <= core_pc;
            tbits <= 6'(PC_W);
        end else if (dclk_fall && tbits != 6'h00) begin
            tpc   <= tsr[0];
            tsr   <= tsr >> 1;
            tbits <= tbits - 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= '0;
        end else begin
            pin_out.tdo    <= trace_mode ? tpc : scan_tdo;
            pin_out.tdo_oe <= trace_mode | scan_oe;
            pin_out.dclk   <= dclk;
            pin_out.pcst   <= trace_mode ? core_pcst : `JDTP_PCST_DBM;
        end
    end

    assign trace_active = trace_mode;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_tap_trst_reset: assert property (!trst_s |=> tap == jdtp_pkg::TAP_TLR)
        else $error("tap not in reset after test reset");
    a_tap_tms_hold: assert property (trst_s && tck_rise && tms_s
        && tap == jdtp_pkg::TAP_TLR |=> tap == jdtp_pkg::TAP_TLR)
        else $error("tap left reset with mode select high");
    a_tck_only_moves: assert property (trst_s && !tck_rise |=> $stable(tap) && $stable(ir_sr))
        else $error("test state moved without a test clock rise");
    a_ir_shift_in: assert property (trst_s && tck_rise && tap == jdtp_pkg::TAP_SIR
        |=> ir_sr[`JDTP_IR_W-1] == $past(tdi_s & ~trace_mode))
        else $error("instruction shift lost data-in bit");
    a_tdo_on_fall: assert property (!tck_fall |=> $stable(scan_tdo) && $stable(scan_oe))
        else $error("scan output changed outside a test clock fall");
    a_tdo_release: assert property (tck_fall && tap != jdtp_pkg::TAP_SIR
        && tap != jdtp_pkg::TAP_SDR && !trace_mode ##1 !trace_mode |=> !pin_out.tdo_oe)
        else $error("data out driven while idle");
    a_dint_stops: assert property (trst_s && trace_mode && !tdi_s |=> !trace_mode)
        else $error("debug interrupt did not stop trace");
    a_trace_pin: assert property (trace_mode |=> pin_out.tdo_oe && pin_out.tdo == $past(tpc))
        else $error("trace stream not on data out");
    a_pc_load: assert property (core_pc_valid && core_pc_ready
        |=> tsr == $past(core_pc) && tbits == 6'(PC_W))
        else $error("pc not captured for trace");
    a_dclk_period: assert property (trace_mode && div == '0 && $past(trace_mode)
        && trst_s && tdi_s |=> dclk != $past(dclk))
        else $error("trace clock did not toggle at full rate");
    a_pcst_dbm: assert property (!trace_mode |=> pin_out.pcst == `JDTP_PCST_DBM)
        else $error("status not debug mode outside trace");

    c_ir_update: cover property (tck_rise && tap == jdtp_pkg::TAP_UIR);
    c_trace_on: cover property ($rose(trace_mode));
    c_pc_sent: cover property (trace_mode && tbits == 6'h01 && dclk_fall);
    c_dint_stop: cover property (trace_mode && !tdi_s);

endmodule

`default_nettype wire

// ==== jdtp_cfg.svh ====
// Purpose: constants for the test-access, debug and trace port
// Assumes: one 100 MHz system clock; all pin inputs are asynchronous to it
// Notes:   every instruction, control and trace constant used by the port lives here; tap state codes are in the package
//
// Summary of operation
// - the test clock is used only to shift and advance the test registers, never as a core clock.
// - the test clock is treated as fully asynchronous to the system and processor clocks.
// - on each test-clock rise the data-in bit shifts into the instruction or selected data register.
// - serial test data out changes only on a test-clock fall.
// - the test data out pin is released (not driven) whenever nothing is being shifted out; the port keeps it driven throughout trace mode.
// - mode select is sampled on each test-clock rise and steers the TAP state machine.
// - in extended debug mode the data-in pin serves as the active-low debug interrupt.
// - a debug interrupt during real-time trace ends trace and returns to standard test operation.
// - in extended debug mode the data-out pin carries the program-counter trace stream.
// - trace carries non-sequential program counter values at half the processor rate or a division of that.
// - a trace capture clock derived from the processor clock is driven out for the tool.
// - a 3-bit trace status code is driven, with 000 meaning debug mode.
`ifndef JDTP_CFG_SVH
`define JDTP_CFG_SVH

`define JDTP_CLK_PERIOD_NS 10
`define JDTP_SYNC_STAGES   2

// instruction register
`define JDTP_IR_W          4
`define JDTP_IR_IDCODE     4'h1
`define JDTP_IR_DBGCTL     4'h8
`define JDTP_IR_BYPASS     4'hF
`define JDTP_IR_CAPTURE    4'h1

// identity word, arbitrary value
`define JDTP_IDCODE_VAL    32'h0000_0ACF

// debug control register: [0] trace mode, [4:1] trace clock divider
`define JDTP_CTL_W         5
`define JDTP_CTL_MODE_BIT  0
`define JDTP_CTL_DIV_LSB   1
`define JDTP_CTL_DIV_W     4
`define JDTP_CTL_RESET     5'h00

// trace
`define JDTP_PC_W          32
`define JDTP_PCST_DBM      3'h0

`endif

// ==== jdtp_pkg.sv ====
// Purpose: types for the test-access, debug and trace port
// Assumes: constants come from jdtp_cfg.svh
// Notes:   tap state codes of the IR column are the DR codes with bit 3 set, capture to update
`include "jdtp_cfg.svh"

package jdtp_pkg;

    typedef enum logic [3:0] {
        TAP_TLR  = 4'hF,
        TAP_RTI  = 4'hC,
        TAP_SDRS = 4'h7,
        TAP_CDR  = 4'h6,
        TAP_SDR  = 4'h2,
        TAP_E1DR = 4'h1,
        TAP_PDR  = 4'h3,
        TAP_E2DR = 4'h0,
        TAP_UDR  = 4'h5,
        TAP_SIRS = 4'h4,
        TAP_CIR  = 4'hE,
        TAP_SIR  = 4'hA,
        TAP_E1IR = 4'h9,
        TAP_PIR  = 4'hB,
        TAP_E2IR = 4'h8,
        TAP_UIR  = 4'hD
    } jdtp_tap_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jdtp_pin_in_s;

    typedef struct packed {
        logic       tdo;
        logic       tdo_oe;
        logic       dclk;
        logic [2:0] pcst;
    } jdtp_pin_out_s;

endpackage

// ==== jdtp_probe.sv ====
// Purpose: behavioural test probe that drives the test pins of the port
// Assumes: pin levels change 1 ns after a clk rise; tck half period is 6 clk
// Notes:   tck stands low between frames; tdi idles high as the pull-up leaves it, tms low to hold run-test-idle
`timescale 1ns/1ns
`default_nettype none

module jdtp_probe (
    input  wire logic                    clk,
    input  wire jdtp_pkg::jdtp_pin_out_s pin_out,
    output var  jdtp_pkg::jdtp_pin_in_s  pin_in
);
    // ----------------------------------------------------------------
    // pin driving
    // ----------------------------------------------------------------
    // held in test reset until first used, tms high as the pull-up gives
    initial begin
        pin_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // 6 clk per half period keeps the oversampled tck clear of the 4 clk minimum
    task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo,
                             output logic oe);
        pin_in.tms = tms;
        pin_in.tdi = tdi;
        tick(6);
        pin_in.tck = 1'b1;
        tdo = pin_out.tdo;
        oe = pin_out.tdo_oe;
        tick(6);
        pin_in.tck = 1'b0;
    endtask

    task automatic trst();
        logic t;
        logic o;
        pin_in.trst_n = 1'b0;
        tick(5);
        pin_in.trst_n = 1'b1;
        tick(5);
        tck_cycle(1'b0, 1'b1, t, o);
    endtask

    task automatic tms_reset();
        logic t;
        logic o;
        repeat (5) tck_cycle(1'b1, 1'b1, t, o);
        tck_cycle(1'b0, 1'b1, t, o);
    endtask

    // from run-test-idle through one shift of n bits, lsb first, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe_ok);
        logic t;
        logic o;
        int   i;
        dout = '0;
        oe_ok = 1'b1;
        tck_cycle(1'b1, 1'b1, t, o);
        if (ir) begin
            tck_cycle(1'b1, 1'b1, t, o);
        end
        tck_cycle(1'b0, 1'b1, t, o);
        tck_cycle(1'b0, 1'b1, t, o);
        for (i = 0; i < n; i++) begin
            tck_cycle(i == n - 1, din[i], t, o);
            dout[i] = t;
            oe_ok &= o;
        end
        tck_cycle(1'b1, 1'b1, t, o);
        tck_cycle(1'b0, 1'b1, t, o);
        oe_ok &= !o;
    endtask

    task automatic hold_tdi(input logic v);
        pin_in.tdi = v;
    endtask
endmodule
`default_nettype wire

// ==== tb_jtag_debug_trace_port.sv ====
// Purpose: self-checking bench for the test, debug and trace port
// Assumes: probe model on the pins, bench plays the core side
// Notes:   trace words are gathered at dclk rises until the first rise after the port is ready again
`timescale 1ns/1ns
`default_nettype none
`include "jdtp_cfg.svh"

module tb_jtag_debug_trace_port;
    logic                    clk;
    logic                    reset_n;
    jdtp_pkg::jdtp_pin_in_s  pin_in;
    jdtp_pkg::jdtp_pin_out_s pin_out;
    logic                    core_pc_valid;
    logic [31:0]             core_pc;
    logic [2:0]              core_pcst;
    logic                    core_pc_ready;
    logic                    trace_active;
    int                      n_fail;
    int                      tests_run;
    int                      cycles;
    int                      seed;
    int                      k;
    int                      c;
    logic [31:0]             r;
    logic [31:0]             dummy;
    logic                    dok;
    logic [3:0]              dv;

    jdtp_port uut (.clk(clk), .reset_n(reset_n), .pin_in(pin_in), .pin_out(pin_out),
        .core_pc_valid(core_pc_valid), .core_pc(core_pc), .core_pcst(core_pcst),
        .core_pc_ready(core_pc_ready), .trace_active(trace_active));
    jdtp_probe probe (.clk(clk), .pin_out(pin_out), .pin_in(pin_in));

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    always #5 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ceiling sits well above the at most roughly 7k cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic jscan(input logic ir, input int n, input logic [31:0] din,
                         input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        probe.scan(ir, n, din, d, ok);
        check("scan_out", d, exp);
        check("tdo_enable", ok, 1'b1);
    endtask

    // offers one pc and gathers the trace stream, measuring dclk half periods
    task automatic send_pc(input logic [31:0] pc, input int hp);
        logic [31:0] w;
        logic        last;
        int          run;
        int          bad;
        int          i;
        bit          seen;
        bit          done;
        bit          fin;
        core_pc = pc;
        core_pcst = pc[31:29];
        core_pc_valid = 1'b1;
        probe.tick(1);
        core_pc_valid = 1'b0;
        check("ready_busy", core_pc_ready, 1'b0);
        w = '0;
        run = 0;
        bad = 0;
        seen = 0;
        done = 0;
        fin = 0;
        last = pin_out.dclk;
        // the last bit reaches the pin after ready returns, so one more dclk rise
        // is gathered then; stale captures before the first bit drop out of w
        for (i = 0; i < 2200 && !fin; i++) begin
            if (core_pc_ready === 1'b1) begin
                done = 1;
            end
            probe.tick(1);
            run++;
            if (pin_out.dclk !== last) begin
                if (pin_out.dclk === 1'b1) begin
                    w = {pin_out.tdo, w[31:1]};
                    fin = done;
                end
                if (seen && run != hp) bad++;
                seen = 1;
                run = 0;
                last = pin_out.dclk;
            end
        end
        check("trace_word", w, pc);
        check("dclk_half_period", bad, 0);
        check("pcst_pass", pin_out.pcst, pc[31:29]);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 57391;
        clk = 1'b0;
        reset_n = 1'b0;
        core_pc_valid = 1'b0;
        core_pc = $random(seed);
        r = $random(seed);
        core_pcst = r[2:0];
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        #1;
        reset_n = 1'b1;
        probe.tick(2);
        check("tdo_oe_reset", pin_out.tdo_oe, 1'b0);
        check("pcst_off", pin_out.pcst, 3'h0);
        check("dclk_off", pin_out.dclk, 1'b0);
        probe.trst();
        jscan(1'b0, 32, 32'h0, `JDTP_IDCODE_VAL);
        jscan(1'b1, 4, `JDTP_IR_BYPASS, `JDTP_IR_CAPTURE);
        r = $random(seed);
        jscan(1'b0, 8, r, {r[6:0], 1'b0});
        probe.tms_reset();
        jscan(1'b0, 32, r, `JDTP_IDCODE_VAL);
        jscan(1'b1, 4, `JDTP_IR_DBGCTL, `JDTP_IR_CAPTURE);
        jscan(1'b0, 5, {r[12:9], 1'b0}, `JDTP_CTL_RESET);
        jscan(1'b0, 5, 32'h0, {r[12:9], 1'b0});
        // divider corners 0 and 15, then a drawn one
        for (k = 0; k < 3; k++) begin
            r = $random(seed);
            dv = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : r[3:0];
            probe.scan(1'b0, 5, {dv, 1'b1}, dummy, dok);
            probe.tick(4);
            check("trace_on", trace_active, 1'b1);
            check("tdo_drive_trace", pin_out.tdo_oe, 1'b1);
            if (k == 0) begin
                for (c = 0; c < 8; c++) begin
                    core_pcst = c[2:0];
                    probe.tick(3);
                    check("pcst_code", pin_out.pcst, c);
                end
            end
            send_pc($random(seed), dv + 1);
            send_pc($random(seed), dv + 1);
            core_pc = $random(seed);
            core_pc_valid = 1'b1;
            probe.tick(1);
            core_pc_valid = 1'b0;
            probe.tick(20);
            probe.hold_tdi(1'b0);
            probe.tick(6);
            check("trace_stop", trace_active, 1'b0);
            probe.tick(2);
            check("pcst_stop", pin_out.pcst, 3'h0);
            check("dclk_stop", pin_out.dclk, 1'b0);
            check("ready_stop", core_pc_ready, 1'b0);
            probe.hold_tdi(1'b1);
            probe.tick(4);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
